// ==== hdl/dst_check.v ====
`timescale 1ns/1ns
`include "rtc_ctl_defs.vh"

module dst_check (
    input  wire       binary_fmt,
    input  wire [7:0] sec_now,
    input  wire [7:0] min_now,
    input  wire [7:0] hour_now,
    input  wire [7:0] dow_now,
    input  wire [7:0] dom_now,
    input  wire [7:0] month_now,
    output wire       spring_jump,
    output wire       fall_back
);
    wire [7:0] v59;
    wire [7:0] v10;
    wire [7:0] v25;
    wire       last_sec;
    wire       sunday;

    assign v59 = binary_fmt ? 8'h3B : 8'h59;
    assign v10 = binary_fmt ? 8'h0A : 8'h10;
    assign v25 = binary_fmt ? 8'h19 : 8'h25;

    // 1:59:59 AM reads 01 in both hour formats
    assign last_sec = (sec_now == v59) && (min_now == v59) && (hour_now == 8'h01);
    assign sunday   = (dow_now == `DOW_SUNDAY);

    // First Sunday falls on date 1..7, last one on 25..31
    assign spring_jump = last_sec && sunday && (month_now == 8'h04) && (dom_now <= 8'h07);
    assign fall_back   = last_sec && sunday && (month_now == v10) && (dom_now >= v25);
endmodule // dst_check

// ==== hdl/rtc_ctl.v ====
`timescale 1ns/1ns
`include "rtc_ctl_defs.vh"

module rtc_ctl (
    input  wire       mclk,
    input  wire       nrst,
    input  wire       rtc_reset,
    input  wire       rtc_disable,
    input  wire       tb_tick,
    input  wire       supply_ok_pin,
    input  wire [7:0] reg_index,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] dom_alarm1_index,
    input  wire [7:0] sec_now,
    input  wire [7:0] min_now,
    input  wire [7:0] hour_now,
    input  wire [7:0] dow_now,
    input  wire [7:0] dom_now,
    input  wire [7:0] month_now,
    input  wire       alarm1_rest_match,
    input  wire       alarm2_match,
    output reg  [7:0] reg_rdata_q,
    output reg        update_strobe_q,
    output reg        dst_advance_q,
    output reg        dst_back_q,
    output reg        number_format_select_q,
    output reg        hour_format_select_q,
    output reg        irq_q
);
    // Control and flag state
    reg  [7:0]  ctl_a_q;
    reg  [7:0]  ctl_b_q;
    reg  [7:0]  ctl_b_d;
    reg  [7:0]  day_of_month_alarm_one_value_q;
    reg         summary_irq_flag_q;
    reg         periodic_flag_q;
    reg         alarm_one_flag_q;
    reg         update_done_flag_q;
    reg         alarm_two_flag_q;
    reg         summary_d;
    reg         periodic_d;
    reg         alarm_one_d;
    reg         update_done_d;
    reg         alarm_two_d;
    reg  [7:0]  rdata_d;

    // Time base and sequencing
    reg  [14:0] tb_cnt_q;
    reg         update_done_pulse_q;
    reg         alarm_eval_q;
    reg         dst_fell_q;
    reg  [2:0]  valid_sync_q;
    reg         supply_valid_q;
    reg  [3:0]  tap;
    reg  [14:0] tap_mask;

    wire        wr_a;
    wire        wr_b;
    wire        wr_dom;
    wire        rd_flags;
    wire        rtc_off;
    wire        update_hold;
    wire [14:0] tb_next;
    wire        second_tick;
    wire        period_event;
    wire        update_go;
    wire        update_in_progress;
    wire        dom_match;
    wire        spring_jump;
    wire        fall_back;
    wire [3:0]  periodic_rate_select;

    assign wr_a     = reg_wr && (reg_index == `IDX_CTL_A);
    assign wr_b     = reg_wr && (reg_index == `IDX_CTL_B);
    assign wr_dom   = reg_wr && (reg_index == dom_alarm1_index);
    assign rd_flags = reg_rd && (reg_index == `IDX_FLAGS);
    assign rtc_off  = rtc_reset || rtc_disable;

    assign update_hold          = ctl_b_q[`B_UPDATE_HOLD];
    assign periodic_rate_select = ctl_a_q[`A_RATE_HI:`A_RATE_LO];

    // Free-running divider on the 32.768 kHz time base
    assign tb_next     = tb_cnt_q + 15'h0001;
    assign second_tick = tb_tick && (tb_cnt_q == 15'h7FFF);

    // No update while held; the second is simply skipped
    assign update_go = second_tick && !update_hold;

    // Warning window before the update, never while held
    assign update_in_progress = !update_hold &&
                                (tb_cnt_q >= (15'h7FFF - `UIP_TICKS + 15'h0001));

    // Rate code to divider tap; codes 1 and 2 alias taps 7 and 8
    always @* begin
        case (periodic_rate_select)
            4'h1:    tap = 4'h7;
            4'h2:    tap = 4'h8;
            default: tap = periodic_rate_select - 4'h1;
        endcase
        tap_mask = (15'h0001 << tap) - 15'h0001;
    end

    // Period is 2^tap time-base ticks: tap 2 is 0.122 ms, tap 14 is 500 ms
    assign period_event = tb_tick && (periodic_rate_select != 4'h0) &&
                          ((tb_next & tap_mask) == 15'h0000);

    // Date field: "11" in the top bits is a wildcard
    assign dom_match = (day_of_month_alarm_one_value_q[7:6] == 2'b11) ||
                       (day_of_month_alarm_one_value_q == dom_now);

    dst_check u_dst (
        .binary_fmt  (ctl_b_q[`B_NUMBER_FORMAT]),
        .sec_now     (sec_now),
        .min_now     (min_now),
        .hour_now    (hour_now),
        .dow_now     (dow_now),
        .dom_now     (dom_now),
        .month_now   (month_now),
        .spring_jump (spring_jump),
        .fall_back   (fall_back)
    );

    // Control B next value
    always @* begin
        ctl_b_d = ctl_b_q;
        if (wr_b) begin
            ctl_b_d = reg_wdata;
        end
        if (rtc_off) begin
            ctl_b_d[`B_PERIODIC_IE]    = 1'b0;
            ctl_b_d[`B_UPDATE_DONE_IE] = 1'b0;
        end
        if (!supply_valid_q) begin
            ctl_b_d[`B_ALARM1_IE] = 1'b0;
            ctl_b_d[`B_ALARM2_IE] = 1'b0;
        end
    end

    // Flags: a set in the read cycle survives the clear
    always @* begin
        periodic_d    = (periodic_flag_q    && !rd_flags) || period_event;
        update_done_d = (update_done_flag_q && !rd_flags) || update_done_pulse_q;
        alarm_one_d   = (alarm_one_flag_q   && !rd_flags) ||
                        (alarm_eval_q && dom_match && alarm1_rest_match);
        alarm_two_d   = (alarm_two_flag_q   && !rd_flags) ||
                        (alarm_eval_q && alarm2_match);
        summary_d     = (summary_irq_flag_q && !rd_flags) ||
                        (periodic_d    && ctl_b_d[`B_PERIODIC_IE]) ||
                        (alarm_one_d   && ctl_b_d[`B_ALARM1_IE]) ||
                        (update_done_d && ctl_b_d[`B_UPDATE_DONE_IE]);
        if (rtc_off) begin
            periodic_d    = 1'b0;
            update_done_d = 1'b0;
            summary_d     = 1'b0;
        end
        if (!supply_valid_q) begin
            alarm_one_d = 1'b0;
            alarm_two_d = 1'b0;
        end
    end

    // Read mux; unmapped indices read zero
    always @* begin
        rdata_d = 8'h00;
        if (reg_index == dom_alarm1_index) begin
            rdata_d = day_of_month_alarm_one_value_q;
        end else begin
            case (reg_index)
                `IDX_CTL_A: begin
                    rdata_d             = ctl_a_q;
                    rdata_d[`A_UIP]     = update_in_progress;
                end
                `IDX_CTL_B: rdata_d = ctl_b_q;
                `IDX_FLAGS: begin
                    rdata_d[`C_SUMMARY]     = summary_irq_flag_q;
                    rdata_d[`C_PERIODIC]    = periodic_flag_q;
                    rdata_d[`C_ALARM1]      = alarm_one_flag_q;
                    rdata_d[`C_UPDATE_DONE] = update_done_flag_q;
                    rdata_d[`C_ALARM2]      = alarm_two_flag_q;
                end
                `IDX_VALID: rdata_d[`D_SUPPLY_VALID] = supply_valid_q;
                default:    rdata_d = 8'h00;
            endcase
        end
    end

    // Supply pin: three stages, change accepted once stages two and three agree
    always @(posedge mclk) begin
        if (!nrst) begin
            valid_sync_q   <= 3'b000;
            supply_valid_q <= 1'b0;
        end else begin
            valid_sync_q <= {valid_sync_q[1:0], supply_ok_pin};
            if (valid_sync_q[1] == valid_sync_q[2]) begin
                supply_valid_q <= valid_sync_q[2];
            end
        end
    end

    // Register file
    always @(posedge mclk) begin
        if (!nrst) begin
            ctl_a_q                        <= `CTL_A_RESET;
            ctl_b_q                        <= `CTL_B_RESET;
            day_of_month_alarm_one_value_q <= `DOM_ALARM1_RESET;
            reg_rdata_q                    <= 8'h00;
        end else begin
            ctl_b_q <= ctl_b_d;
            if (wr_a) begin
                // UPDATE_IN_PROGRESS is status only, never stored
                ctl_a_q <= {1'b0, reg_wdata[6:0]};
            end
            if (wr_dom) begin
                // Range is software's duty; any byte is stored
                day_of_month_alarm_one_value_q <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

    // Flag registers
    always @(posedge mclk) begin
        if (!nrst) begin
            summary_irq_flag_q <= 1'b0;
            periodic_flag_q    <= 1'b0;
            alarm_one_flag_q   <= 1'b0;
            update_done_flag_q <= 1'b0;
            alarm_two_flag_q   <= 1'b0;
            irq_q              <= 1'b0;
        end else begin
            summary_irq_flag_q <= summary_d;
            periodic_flag_q    <= periodic_d;
            alarm_one_flag_q   <= alarm_one_d;
            update_done_flag_q <= update_done_d;
            alarm_two_flag_q   <= alarm_two_d;
            irq_q              <= summary_d;
        end
    end

    // Update sequencing: strobe, done, then alarm compare
    always @(posedge mclk) begin
        if (!nrst) begin
            tb_cnt_q               <= 15'h0000;
            update_strobe_q        <= 1'b0;
            dst_advance_q          <= 1'b0;
            dst_back_q             <= 1'b0;
            update_done_pulse_q    <= 1'b0;
            alarm_eval_q           <= 1'b0;
            dst_fell_q             <= 1'b0;
            number_format_select_q <= 1'b0;
            hour_format_select_q   <= 1'b0;
        end else begin
            if (tb_tick) begin
                tb_cnt_q <= tb_next;
            end
            update_strobe_q     <= update_go;
            dst_advance_q       <= update_go && ctl_b_q[`B_DAYLIGHT_SAVING] && spring_jump;
            dst_back_q          <= update_go && ctl_b_q[`B_DAYLIGHT_SAVING] &&
                                   fall_back && !dst_fell_q;
            update_done_pulse_q <= update_strobe_q;
            // Compare one cycle after counters have taken the new second
            alarm_eval_q        <= update_done_pulse_q;
            // Guards the repeated 1 AM hour from a second fall-back
            if (update_go && ctl_b_q[`B_DAYLIGHT_SAVING] && fall_back) begin
                dst_fell_q <= 1'b1;
            end else if (dow_now != `DOW_SUNDAY) begin
                dst_fell_q <= 1'b0;
            end
            number_format_select_q <= ctl_b_q[`B_NUMBER_FORMAT];
            // PM flag in bit 7 is kept by the hour counter
            hour_format_select_q   <= ctl_b_q[`B_HOUR_FORMAT];
        end
    end
endmodule // rtc_ctl

// ==== include/rtc_ctl_defs.vh ====
`ifndef RTC_CTL_DEFS_VH
`define RTC_CTL_DEFS_VH

// Register indices on the index/data port, and register reset values
`define IDX_CTL_A          8'h0A
`define IDX_CTL_B          8'h0B
`define IDX_FLAGS          8'h0C
`define IDX_VALID          8'h0D
`define DOM_ALARM1_RESET   8'hC0
`define CTL_A_RESET        8'h20
`define CTL_B_RESET        8'h00

// Control B bits
`define B_UPDATE_HOLD      7
`define B_PERIODIC_IE      6
`define B_ALARM1_IE        5
`define B_UPDATE_DONE_IE   4
`define B_ALARM2_IE        3
`define B_NUMBER_FORMAT    2
`define B_HOUR_FORMAT      1
`define B_DAYLIGHT_SAVING  0

// Flag register bits
`define C_SUMMARY          7
`define C_PERIODIC         6
`define C_ALARM1           5
`define C_UPDATE_DONE      4
`define C_ALARM2           3

// Control A fields
`define A_UIP              7
`define A_DIV_HI           6
`define A_DIV_LO           4
`define A_RATE_HI          3
`define A_RATE_LO          0

// Validity register
`define D_SUPPLY_VALID     7

// Time base
`define TB_HZ              32768
`define UIP_LEAD_US        244
`define UIP_TICKS          ((`UIP_LEAD_US * `TB_HZ) / 1000000)
`define DOW_SUNDAY         8'h01

`endif

// ==== testbench/rtc_ctl_props.sv ====
`timescale 1ns/1ns
module rtc_ctl_props (
    input wire       mclk,
    input wire       nrst,
    input wire       rtc_reset,
    input wire [7:0] reg_index,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] dom_alarm1_index,
    input wire [7:0] reg_rdata_q,
    input wire       update_strobe_q,
    input wire       dst_advance_q,
    input wire       dst_back_q,
    input wire       number_format_select_q,
    input wire       hour_format_select_q,
    input wire       irq_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire wr_b = reg_wr && reg_index == 8'h0B && dom_alarm1_index != 8'h0B;
    wire rd_c = reg_rd && reg_index == 8'h0C && dom_alarm1_index != 8'h0C;
    wire rd_d = reg_rd && reg_index == 8'h0D && dom_alarm1_index != 8'h0D;
    reg  hold_q;
    // Mirror of the hold bit, needed because control B is not a port
    always @(posedge mclk) begin
        if (!nrst) hold_q <= 1'b0;
        else if (wr_b) hold_q <= reg_wdata[7];
    end
    a_hold_no_update: assert property (hold_q && $past(hold_q) |-> !update_strobe_q)
        else $error("update while hold set");
    a_number_fmt_out: assert property (wr_b |-> ##2 number_format_select_q == $past(reg_wdata[2], 2))
        else $error("number format output wrong");
    a_hour_fmt_out: assert property (wr_b |-> ##2 hour_format_select_q == $past(reg_wdata[1], 2))
        else $error("hour format output wrong");
    a_advance_with_strobe: assert property (dst_advance_q |-> update_strobe_q)
        else $error("advance without update");
    a_back_with_strobe: assert property (dst_back_q |-> update_strobe_q)
        else $error("step back without update");
    a_summary_read_back: assert property (rd_c |=> reg_rdata_q[7] == $past(irq_q))
        else $error("summary bit differs from irq");
    a_reset_drops_irq: assert property (rtc_reset |=> !irq_q)
        else $error("irq kept through rtc reset");
    a_valid_low_zero: assert property (rd_d |=> reg_rdata_q[6:0] == 7'h00)
        else $error("validity low bits not zero");
    a_flags_low_zero: assert property (rd_c |=> reg_rdata_q[2:0] == 3'h0)
        else $error("flag reserved bits not zero");
    a_strobe_single: assert property (update_strobe_q |=> !update_strobe_q)
        else $error("update strobe too long");
    c_update: cover property (update_strobe_q && dst_advance_q);
    c_irq_read: cover property (rd_c && irq_q);
    c_hold: cover property (hold_q && $past(hold_q));
    c_fall_back: cover property (update_strobe_q && dst_back_q);
endmodule // rtc_ctl_props
bind rtc_ctl rtc_ctl_props u_props (
    .mclk                   (mclk),
    .nrst                   (nrst),
    .rtc_reset              (rtc_reset),
    .reg_index              (reg_index),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .dom_alarm1_index       (dom_alarm1_index),
    .reg_rdata_q            (reg_rdata_q),
    .update_strobe_q        (update_strobe_q),
    .dst_advance_q          (dst_advance_q),
    .dst_back_q             (dst_back_q),
    .number_format_select_q (number_format_select_q),
    .hour_format_select_q   (hour_format_select_q),
    .irq_q                  (irq_q)
);

// ==== testbench/tb_rtc_ctl.sv ====
`timescale 1ns/1ns
module tb_rtc_ctl;
    reg        mclk = 0, nrst = 0, rtc_reset = 0, rtc_disable = 0, tb_tick = 0, supply_ok_pin = 1;
    reg        reg_wr = 0, reg_rd = 0, alarm1_rest_match = 0, alarm2_match = 0;
    reg  [7:0] reg_index = 8'h00, reg_wdata = 8'h00, dom_alarm1_index = 8'h20;
    reg  [7:0] sec_now = 8'h59, min_now = 8'h59, hour_now = 8'h01;
    reg  [7:0] dow_now = 8'h01, dom_now = 8'h01, month_now = 8'h04;
    wire [7:0] reg_rdata_q;
    wire       update_strobe_q, dst_advance_q, dst_back_q;
    wire       number_format_select_q, hour_format_select_q, irq_q;
    integer    num_errors = 0, check_count = 0, cyc = 0, n, i;
    rtc_ctl dut (
        .mclk                   (mclk),
        .nrst                   (nrst),
        .rtc_reset              (rtc_reset),
        .rtc_disable            (rtc_disable),
        .tb_tick                (tb_tick),
        .supply_ok_pin          (supply_ok_pin),
        .reg_index              (reg_index),
        .reg_wdata              (reg_wdata),
        .reg_wr                 (reg_wr),
        .reg_rd                 (reg_rd),
        .dom_alarm1_index       (dom_alarm1_index),
        .sec_now                (sec_now),
        .min_now                (min_now),
        .hour_now               (hour_now),
        .dow_now                (dow_now),
        .dom_now                (dom_now),
        .month_now              (month_now),
        .alarm1_rest_match      (alarm1_rest_match),
        .alarm2_match           (alarm2_match),
        .reg_rdata_q            (reg_rdata_q),
        .update_strobe_q        (update_strobe_q),
        .dst_advance_q          (dst_advance_q),
        .dst_back_q             (dst_back_q),
        .number_format_select_q (number_format_select_q),
        .hour_format_select_q   (hour_format_select_q),
        .irq_q                  (irq_q)
    );
    always #4 mclk = ~mclk;
    task test_done;
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hang guard: three full seconds of ticks plus margin
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 99500) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    task chk(input [7:0] got, input [7:0] exp, input [7:0] msk);
        check_count = check_count + 1;
        if ((got & msk) !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        @(posedge mclk) #1;
        reg_wr = 1; reg_index = idx; reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr = 0;
    endtask
    task rd(input [7:0] idx, input [7:0] exp, input [7:0] msk);
        @(posedge mclk) #1;
        reg_rd = 1; reg_index = idx;
        @(posedge mclk) #1;
        reg_rd = 0;
        chk(reg_rdata_q, exp, msk);
    endtask
    task ticks(input integer k);
        @(posedge mclk) #1;
        tb_tick = 1;
        repeat (k) @(posedge mclk) #1;
        tb_tick = 0;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #1 nrst = 1;
        rd(8'h0B, 8'h00, 8'hFF);
        rd(8'h0C, 8'h00, 8'hFF);
        rd(8'h20, 8'hC0, 8'hFF);
        repeat (4) @(posedge mclk);
        rd(8'h0D, 8'h80, 8'hFF);
        wr(8'h0B, 8'h06);
        rd(8'h0B, 8'h06, 8'hFF);
        chk({6'h00, number_format_select_q, hour_format_select_q}, 8'h03, 8'hFF);
        wr(8'h20, 8'h1F);
        rd(8'h20, 8'h1F, 8'hFF);
        wr(8'h20, 8'hC0);
        // Move the date alarm to another index; old index goes unmapped
        dom_alarm1_index = 8'h30;
        rd(8'h30, 8'hC0, 8'hFF);
        rd(8'h20, 8'h00, 8'hFF);
        dom_alarm1_index = 8'h20;
        wr(8'h0B, 8'h28);
        rd(8'h0B, 8'h28, 8'hFF);
        supply_ok_pin = 0;
        repeat (6) @(posedge mclk) #1;
        rd(8'h0B, 8'h00, 8'hFF);
        rd(8'h0D, 8'h00, 8'hFF);
        supply_ok_pin = 1;
        repeat (6) @(posedge mclk) #1;
        // Rate code 3: shortest period, four ticks
        wr(8'h0A, 8'h23);
        wr(8'h0B, 8'h50);
        ticks(8);
        rd(8'h0C, 8'hC0, 8'hF8);
        rd(8'h0C, 8'h00, 8'hFF);
        for (i = 0; i < 2; i = i + 1) begin
            ticks(8);
            {rtc_disable, rtc_reset} = i ? 2'b10 : 2'b01;
            @(posedge mclk) #1;
            {rtc_disable, rtc_reset} = 2'b00;
            rd(8'h0B, 8'h00, 8'hFF);
            rd(8'h0C, 8'h00, 8'hFF);
            wr(8'h0B, 8'h50);
        end
        wr(8'h0A, 8'h20);
        ticks(64);
        rd(8'h0C, 8'h00, 8'hFF);
        wr(8'h0B, 8'h80);
        rd(8'h0A, 8'h00, 8'h80);
        alarm1_rest_match = 1;
        alarm2_match = 1;
        tb_tick = 1;
        n = 0;
        repeat (33000) @(posedge mclk) #1 n = n + update_strobe_q;
        chk((n > 255) ? 8'hFF : n[7:0], 8'h00, 8'hFF);
        rd(8'h0C, 8'h00, 8'hFF);
        // Alarm date C0h is a wildcard, so both alarms match
        wr(8'h0B, 8'h39);
        // Freeze the time base inside the warning window
        reg_index = 8'h0A;
        reg_rd = 1;
        for (n = 0; n < 33000 && reg_rdata_q[7] !== 1'b1; n = n + 1) @(posedge mclk) #1;
        reg_rd = 0;
        tb_tick = 0;
        chk(reg_rdata_q, 8'h80, 8'h80);
        wr(8'h0B, 8'hB9);
        rd(8'h0A, 8'h00, 8'h80);
        wr(8'h0B, 8'h39);
        tb_tick = 1;
        for (n = 0; n < 33000 && update_strobe_q !== 1'b1; n = n + 1) @(posedge mclk) #1;
        chk({6'h00, dst_back_q, dst_advance_q}, 8'h01, 8'hFF);
        tb_tick = 0;
        repeat (5) @(posedge mclk) #1;
        rd(8'h0C, 8'hB8, 8'hFF);
        rd(8'h0C, 8'h00, 8'hFF);
        // Last October Sunday; alarm date compared, one day off
        wr(8'h20, 8'h26);
        month_now = 8'h10;
        dom_now = 8'h25;
        tb_tick = 1;
        for (n = 0; n < 33000 && update_strobe_q !== 1'b1; n = n + 1) @(posedge mclk) #1;
        chk({6'h00, dst_back_q, dst_advance_q}, 8'h02, 8'hFF);
        tb_tick = 0;
        repeat (5) @(posedge mclk) #1;
        rd(8'h0C, 8'h98, 8'hFF);
        test_done;
    end
endmodule // tb_rtc_ctl
